// *** logic/sfp_port.sv ***
// The placing of the registers and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "sfp_consts.svh"
module sfp_port import sfp_pkg::*; #(
  parameter bit IS_MASTER = 1'b1,
  parameter int DEPTH = `SFP_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire sfp_link_in_s link_in,
  output sfp_link_out_s link_out,
  output sfp_irq_s irq,
  output sfp_dma_s dma_req,
  input wire sfp_dma_s dma_ack
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
  localparam logic [AW:0] RX_LVL = (AW+1)'(`SFP_RX_LEVEL);
  localparam logic [AW:0] TX_LVL = (AW+1)'(`SFP_TX_LEVEL);
  localparam logic [6:0] TO_HALVES = 7'(2 * `SFP_TO_BITS);

  if (DEPTH != `SFP_DEPTH) begin : g_bad_depth
    $error("sfp_port: FIFO depth must be eight");
  end

  typedef struct packed {
    sfp_eng_e eng;
    logic [15:0] hc;
    logic [4:0] ec;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic [DEPTH-1:0][15:0] txm;
    logic [DEPTH-1:0][15:0] rxm;
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0] tx_cnt;
    logic [AW:0] rx_cnt;
    logic [15:0] cr0;
    logic en;
    logic [7:0] cpsr;
    logic [3:0] imsc;
    logic ror;
    logic rt;
    logic [1:0] dmac;
    logic [6:0] to_cnt;
    sfp_link_in_s sy1;
    sfp_link_in_s sy2;
    sfp_link_in_s sy3;
    sfp_link_out_s lo;
    sfp_irq_s irq;
    sfp_dma_s req;
    logic a_wr;
    logic [7:0] a_ofs;
    logic [31:0] rdata;
    logic hready;
  } sfp_state_s;

  sfp_state_s st;
  sfp_state_s n;

  logic cpha;
  logic cpol;
  logic [3:0] dss;
  logic [6:0] pre;
  logic [15:0] half;
  logic tick;
  logic edge_ev;
  logic cap;
  logic lnc;
  logic [4:0] last_ec;
  logic [4:0] cap_last;
  logic busy;
  logic more;
  logic rx_push;
  logic [15:0] rx_word;
  logic rx_pop;
  logic tx_pop;
  logic tx_wr;
  logic [15:0] tx_head;
  logic [3:0] raw;
  logic [3:0] mis;
  logic a_sel;
  logic [7:0] ofs;

  always_comb begin
    n = st;
    cpha = st.cr0[`SFP_CTRL0_PHASE];
    cpol = st.cr0[`SFP_CTRL0_POL];
    dss = (st.cr0[3:0] < `SFP_MIN_SIZE) ? `SFP_MIN_SIZE : st.cr0[3:0];
    pre = (st.cpsr[7:1] == 7'h00) ? 7'h01 : st.cpsr[7:1];
    half = 16'({9'h000, pre}) * (16'({8'h00, st.cr0[15:8]}) + 16'h0001);
    tick = (st.hc == 16'h0000);
    n.hc = tick ? (half - 16'h0001) : (st.hc - 16'h0001);
    last_ec = {dss, 1'b1};
    cap_last = {dss, cpha};
    tx_head = 16'(st.txm[st.tx_rp] << (4'hF - dss));
    more = st.en && (st.tx_cnt != '0);
    rx_push = 1'b0;
    tx_pop = 1'b0;
    rx_word = 16'({st.rx_sh[14:0], st.sy2.serial_rx_line} & (16'hFFFF >> (4'hF - dss)));
    n.sy1 = link_in;
    n.sy2 = st.sy1;
    n.sy3 = st.sy2;
    n.lo.serial_bit_clock_oe = IS_MASTER;
    if (IS_MASTER) begin
      busy = (st.eng != eng_idle);
      edge_ev = (st.eng == eng_bits) && tick;
    end else begin
      busy = !st.sy2.sel_n;
      edge_ev = !st.sy2.sel_n && !st.sy3.sel_n
        && (st.sy2.serial_bit_clock != st.sy3.serial_bit_clock);
    end
    cap = edge_ev && (st.ec[0] == cpha);
    lnc = edge_ev && (st.ec[0] != cpha) && (st.ec != 5'h00);
    if (cap) begin
      n.rx_sh = {st.rx_sh[14:0], st.sy2.serial_rx_line};
      rx_push = (st.ec == cap_last);
    end
    if (lnc) begin
      n.tx_sh = {st.tx_sh[14:0], 1'b0};
      n.lo.serial_tx_line = st.tx_sh[14];
    end
    if (IS_MASTER) begin
      case (st.eng)
        eng_idle: begin
          n.lo.sel_n = 1'b1;
          n.lo.serial_tx_line = 1'b0;
          n.lo.tx_output_enable_n = 1'b1;
          n.lo.serial_bit_clock = cpol;
          if (more && tick) begin
            n.eng = eng_lead;
            n.lo.sel_n = 1'b0;
            n.lo.tx_output_enable_n = 1'b0;
            n.tx_sh = tx_head;
            tx_pop = 1'b1;
          end
        end
        eng_lead: begin
          if (tick) begin
            n.eng = eng_bits;
            n.lo.serial_tx_line = st.tx_sh[15];
            if (cpha) begin
              n.lo.serial_bit_clock = ~st.lo.serial_bit_clock;
              n.ec = 5'h01;
            end else begin
              n.ec = 5'h00;
            end
          end
        end
        eng_bits: begin
          if (tick) begin
            n.lo.serial_bit_clock = ~st.lo.serial_bit_clock;
            n.ec = st.ec + 5'h01;
            if (st.ec == last_ec) begin
              if (cpha && more) begin
                n.eng = eng_lead;
                n.tx_sh = tx_head;
                tx_pop = 1'b1;
              end else begin
                n.eng = eng_trail;
                n.ec = {4'h0, cpha};
              end
            end
          end
        end
        eng_trail: begin
          if (tick) begin
            n.ec = st.ec - 5'h01;
            if (st.ec == 5'h00) begin
              n.lo.sel_n = 1'b1;
              n.lo.serial_tx_line = 1'b0;
              n.lo.tx_output_enable_n = 1'b1;
              n.lo.serial_bit_clock = cpol;
              n.eng = (!cpha && more) ? eng_gap : eng_idle;
            end
          end
        end
        eng_gap: begin
          if (tick) begin
            n.eng = eng_lead;
            n.lo.sel_n = 1'b0;
            n.lo.tx_output_enable_n = 1'b0;
            n.tx_sh = tx_head;
            tx_pop = 1'b1;
          end
        end
        default: begin
          n.eng = eng_idle;
        end
      endcase
    end else begin
      n.eng = eng_idle;
      n.lo.sel_n = 1'b1;
      n.lo.serial_bit_clock = cpol;
      if (st.sy2.sel_n) begin
        n.lo.tx_output_enable_n = 1'b1;
        n.lo.serial_tx_line = 1'b0;
      end else if (st.sy3.sel_n) begin
        n.ec = 5'h00;
        n.lo.tx_output_enable_n = 1'b0;
        n.tx_sh = (st.tx_cnt != '0) ? tx_head : 16'h0000;
        n.lo.serial_tx_line = (st.tx_cnt != '0) ? tx_head[15] : 1'b0;
        tx_pop = (st.tx_cnt != '0);
      end else if (edge_ev) begin
        n.ec = (st.ec == last_ec) ? 5'h00 : (st.ec + 5'h01);
        if (cpha && (st.ec == last_ec)) begin
          n.tx_sh = (st.tx_cnt != '0) ? tx_head : 16'h0000;
          n.lo.serial_tx_line = (st.tx_cnt != '0) ? tx_head[15] : 1'b0;
          tx_pop = (st.tx_cnt != '0);
        end
      end
    end

    a_sel = hsel && htrans[1] && hready;
    ofs = {haddr[7:2], 2'b00};
    n.hready = 1'b1;
    n.a_wr = a_sel && hwrite;
    n.a_ofs = ofs;
    raw = {st.tx_cnt <= TX_LVL, st.rx_cnt >= RX_LVL, st.rt, st.ror};
    mis = raw & st.imsc & {~st.dmac[`SFP_DMA_TX], ~st.dmac[`SFP_DMA_RX], 2'b11};
    rx_pop = 1'b0;
    n.rdata = 32'h0000_0000;
    if (a_sel && !hwrite) begin
      case (ofs)
        `SFP_OFS_CTRL0: n.rdata = {16'h0000, st.cr0};
        `SFP_OFS_CTRL1: n.rdata = {30'h0, st.en, 1'b0};
        `SFP_OFS_DATA: begin
          n.rdata = {16'h0000, st.rxm[st.rx_rp]};
          rx_pop = (st.rx_cnt != '0);
        end
        `SFP_OFS_STATUS: n.rdata = {27'h0, busy, st.rx_cnt == FULL, st.rx_cnt != '0,
                                    st.tx_cnt != FULL, st.tx_cnt == '0};
        `SFP_OFS_PRESCALE: n.rdata = {24'h0, st.cpsr};
        `SFP_OFS_IMASK: n.rdata = {28'h0, st.imsc};
        `SFP_OFS_RAW: n.rdata = {28'h0, raw};
        `SFP_OFS_MASKED: n.rdata = {28'h0, mis};
        `SFP_OFS_DMACTL: n.rdata = {30'h0, st.dmac};
        default: n.rdata = 32'h0000_0000;
      endcase
    end
    tx_wr = 1'b0;
    if (st.a_wr) begin
      case (st.a_ofs)
        `SFP_OFS_CTRL0: n.cr0 = hwdata[15:0];
        `SFP_OFS_CTRL1: n.en = hwdata[`SFP_CTRL1_ENABLE];
        `SFP_OFS_DATA: tx_wr = (st.tx_cnt != FULL);
        `SFP_OFS_PRESCALE: n.cpsr = hwdata[7:0];
        `SFP_OFS_IMASK: n.imsc = hwdata[3:0];
        `SFP_OFS_ICLR: begin
          if (hwdata[`SFP_IRQ_ROR]) begin
            n.ror = 1'b0;
          end
          if (hwdata[`SFP_IRQ_RT]) begin
            n.rt = 1'b0;
          end
        end
        `SFP_OFS_DMACTL: n.dmac = hwdata[1:0];
        default: n.dmac = st.dmac;
      endcase
    end

    if (tx_wr) begin
      n.txm[st.tx_wp] = hwdata[15:0];
      n.tx_wp = st.tx_wp + 1'b1;
    end
    if (tx_pop) begin
      n.tx_rp = st.tx_rp + 1'b1;
    end
    n.tx_cnt = st.tx_cnt + (AW+1)'(tx_wr) - (AW+1)'(tx_pop);
    if (rx_push && (st.rx_cnt == FULL)) begin
      n.ror = 1'b1;
    end
    if (rx_push && (st.rx_cnt != FULL)) begin
      n.rxm[st.rx_wp] = rx_word;
      n.rx_wp = st.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      n.rx_rp = st.rx_rp + 1'b1;
    end
    n.rx_cnt = st.rx_cnt + (AW+1)'(rx_push && (st.rx_cnt != FULL)) - (AW+1)'(rx_pop);

    if (busy || (st.rx_cnt == '0) || rx_push) begin
      n.to_cnt = 7'h00;
    end else if (tick && (st.to_cnt != TO_HALVES)) begin
      n.to_cnt = st.to_cnt + 7'h01;
    end
    if ((n.rx_cnt == '0) || rx_push) begin
      n.rt = 1'b0;
    end
    if (tick && (st.to_cnt == TO_HALVES - 7'h01) && !busy && (st.rx_cnt != '0) && !rx_push) begin
      n.rt = 1'b1;
    end

    n.irq.rx_service_irq = mis[`SFP_IRQ_RX];
    n.irq.tx_service_irq = mis[`SFP_IRQ_TX];
    n.irq.rx_overrun_irq = mis[`SFP_IRQ_ROR];
    n.irq.rx_timeout_irq = mis[`SFP_IRQ_RT];
    n.irq.combined_irq = |mis;
    n.req.tx = st.dmac[`SFP_DMA_TX] && (st.tx_cnt != FULL) && !dma_ack.tx;
    n.req.rx = st.dmac[`SFP_DMA_RX] && (st.rx_cnt != '0) && !dma_ack.rx;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.cr0 <= `SFP_CTRL0_RST;
      st.cpsr <= `SFP_PRESCALE_RST;
      st.sy1.sel_n <= 1'b1;
      st.sy2.sel_n <= 1'b1;
      st.sy3.sel_n <= 1'b1;
      st.lo.sel_n <= 1'b1;
      st.lo.tx_output_enable_n <= 1'b1;
      st.lo.serial_bit_clock_oe <= IS_MASTER;
      st.hready <= 1'b1;
    end else begin
      st <= n;
    end
  end

  assign hreadyout = st.hready;
  assign hrdata = st.rdata;
  assign hresp = 1'b0;
  assign link_out = st.lo;
  assign irq = st.irq;
  assign dma_req = st.req;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  idle_clock_level_a: assert property (
    IS_MASTER && st.eng == eng_idle && $past(st.eng) == eng_idle && $stable(st.cr0)
    |-> st.lo.serial_bit_clock == st.cr0[`SFP_CTRL0_POL])
    else $error("idle clock not at polarity level");
  idle_lines_quiet_a: assert property (
    IS_MASTER && st.eng == eng_idle |-> st.lo.sel_n && !st.lo.serial_tx_line)
    else $error("idle select or data line wrong");
  clock_drive_role_a: assert property (
    st.lo.serial_bit_clock_oe == IS_MASTER)
    else $error("clock driver enable does not match role");
  frame_start_cause_a: assert property (
    IS_MASTER && st.eng == eng_idle ##1 st.eng == eng_lead
    |-> $past(st.en) && $past(st.tx_cnt) != '0 && !st.lo.sel_n && !st.lo.tx_output_enable_n)
    else $error("frame started without enable or data");
  phase1_sel_held_a: assert property (
    IS_MASTER && st.eng == eng_bits && st.cr0[`SFP_CTRL0_PHASE] ##1 st.eng == eng_lead
    |-> !st.lo.sel_n)
    else $error("select released between phase 1 words");
  phase0_sel_pulse_a: assert property (
    IS_MASTER && st.eng == eng_gap |-> st.lo.sel_n)
    else $error("select not pulsed high between phase 0 words");
  rx_level_irq_a: assert property (
    st.rx_cnt >= RX_LVL && st.imsc[`SFP_IRQ_RX] && !st.dmac[`SFP_DMA_RX] && $stable(st.rx_cnt)
    |=> st.irq.rx_service_irq)
    else $error("receive service interrupt missing");
  tx_level_irq_a: assert property (
    st.imsc[`SFP_IRQ_TX] && !st.dmac[`SFP_DMA_TX] |=> st.irq.tx_service_irq == ($past(st.tx_cnt) <= TX_LVL))
    else $error("transmit service interrupt wrong");
  overrun_keeps_fifo_a: assert property (
    rx_push && st.rx_cnt == FULL && !rx_pop |=> st.ror && st.rx_cnt == FULL && $stable(st.rxm))
    else $error("overrun did not flag or fifo changed");
  combined_or_a: assert property (
    ##1 st.irq.combined_irq == (st.irq.rx_service_irq | st.irq.tx_service_irq
    | st.irq.rx_overrun_irq | st.irq.rx_timeout_irq))
    else $error("combined interrupt not the OR of sources");
  timeout_cleared_a: assert property (
    rx_push |=> !st.rt)
    else $error("timeout not cleared by new data");
endmodule

// *** common/sfp_consts.svh ***
// Operation
// - Idle master clock output rests at the polarity level.
// - Idle select stays high and transmit line stays low.
// - Master drives the serial clock; slave leaves it undriven and uses the input.
// - Master starts a frame only when enabled with transmit data; select low, driver on.
// - Phase 1: data and first clock edge come half a period after select falls; slave drives its first bit at select fall.
// - Polarity 0 phase 1: sample on falling edges, change on rising edges.
// - Polarity 1 phase 1: sample on rising edges, change on falling edges.
// - Polarity 1 phase 0: slave data at select fall, master half later.
// - Master raises select one full period after the last captured bit.
// - Phase 0: select pulses high between words; slave reloads only after select rises.
// - Phase 1: select stays low across back-to-back words until the last.
// - Each instance is fixed as master or slave.
// - Transmit DMA requests while the transmit buffer has room; engine acknowledges.
// - Receive DMA requests while the receive buffer holds data; engine acknowledges.
// - DMA mode replaces the service interrupt of that direction.
// - Four separate active-high interrupts plus one combined output.
// - Each source has a mask bit; one enables its output.
// - Raw and masked interrupt status are both readable.
// - Receive service interrupt when receive FIFO holds four or more entries.
// - Transmit service interrupt at four or fewer entries, not gated by enable.
// - Frame into full receive FIFO raises overrun; FIFO contents kept.
// - Timeout after 32 idle bit periods with data; cleared by empty, data, or clear bit.
// - Both FIFOs are 16 bits wide and eight entries deep.
// - Frames carry 4 to 16 bits, most significant bit first.
`ifndef SFP_CONSTS_SVH
`define SFP_CONSTS_SVH
`define SFP_OFS_CTRL0 8'h00
`define SFP_OFS_CTRL1 8'h04
`define SFP_OFS_DATA 8'h08
`define SFP_OFS_STATUS 8'h0C
`define SFP_OFS_PRESCALE 8'h10
`define SFP_OFS_IMASK 8'h14
`define SFP_OFS_RAW 8'h18
`define SFP_OFS_MASKED 8'h1C
`define SFP_OFS_ICLR 8'h20
`define SFP_OFS_DMACTL 8'h24
`define SFP_CTRL0_PHASE 7
`define SFP_CTRL0_POL 6
`define SFP_CTRL1_ENABLE 1
`define SFP_DMA_RX 0
`define SFP_DMA_TX 1
`define SFP_IRQ_ROR 0
`define SFP_IRQ_RT 1
`define SFP_IRQ_RX 2
`define SFP_IRQ_TX 3
`define SFP_CTRL0_RST 16'h0000
`define SFP_PRESCALE_RST 8'h00
`define SFP_MIN_SIZE 4'h3
`define SFP_RX_LEVEL 4
`define SFP_TX_LEVEL 4
`define SFP_TO_BITS 32
`define SFP_DEPTH 8
`endif

// *** common/sfp_pkg.sv ***
package sfp_pkg;
  typedef enum logic [2:0] {
    eng_idle = 3'b000,
    eng_lead = 3'b001,
    eng_bits = 3'b011,
    eng_trail = 3'b010,
    eng_gap = 3'b110
  } sfp_eng_e;
  typedef struct packed {
    logic serial_bit_clock;
    logic sel_n;
    logic serial_rx_line;
  } sfp_link_in_s;
  typedef struct packed {
    logic serial_bit_clock;
    logic serial_bit_clock_oe;
    logic sel_n;
    logic serial_tx_line;
    logic tx_output_enable_n;
  } sfp_link_out_s;
  typedef struct packed {
    logic rx_service_irq;
    logic tx_service_irq;
    logic rx_overrun_irq;
    logic rx_timeout_irq;
    logic combined_irq;
  } sfp_irq_s;
  typedef struct packed {
    logic rx;
    logic tx;
  } sfp_dma_s;
endpackage

// *** dv/sfp_slave_model.sv ***
`timescale 1ns/1ps
module sfp_slave_model import sfp_pkg::*; (
  input wire logic hclk,
  input wire sfp_link_out_s lo,
  input wire logic pol,
  input wire logic ph,
  input wire logic [4:0] nbits,
  input wire logic [15:0] miso_word,
  output logic miso,
  output logic [15:0] got,
  output int n_words
);
  logic [15:0] sh;
  logic [15:0] rxs;
  logic last_clk;
  logic last_sel;
  logic lead;
  int cnt;
  initial begin
    miso = 1'b0;
    got = 16'h0000;
    n_words = 0;
    cnt = 0;
    last_clk = 1'b0;
    last_sel = 1'b1;
    sh = 16'h0000;
    rxs = 16'h0000;
  end
  always @(posedge hclk) begin
    lead = (lo.serial_bit_clock != pol);
    if (lo.sel_n) begin
      // Released line shows no stale value
      miso <= ~miso;
      cnt = 0;
    end else if (last_sel) begin
      // Phase 0 loads only at select fall, frozen after
      sh = miso_word + 16'(n_words);
      if (!ph) begin
        miso <= sh[nbits - 5'd1];
      end
    end else if (lo.serial_bit_clock != last_clk) begin
      if (lead == ph) begin
        if (ph && cnt == 0) begin
          sh = miso_word + 16'(n_words);
        end
        if (cnt < int'(nbits)) begin
          miso <= sh[nbits - 5'd1 - 5'(cnt)];
        end
      end else begin
        rxs = {rxs[14:0], lo.serial_tx_line};
        cnt++;
        if (cnt == int'(nbits)) begin
          got = rxs & 16'((32'h1 << nbits) - 1);
          n_words++;
          cnt = 0;
        end
      end
    end
    last_clk = lo.serial_bit_clock;
    last_sel = lo.sel_n;
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  import sfp_pkg::*;
  logic hclk, hresetn, hwrite, hreadyout, hresp, miso, pol, ph, sel_q, mon;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, r, mw;
  logic [4:0] nbits;
  logic [15:0] got, w, msk;
  int seed, n_words, n_mismatch, n_compared, cycles, sel_rise, k;
  int nb_tab[4] = '{4, 16, 7, 12};
  logic [15:0] rxq[$];
  sfp_link_in_s lin;
  sfp_link_out_s lo;
  sfp_irq_s irq;
  sfp_dma_s dreq, dack;
  assign lin = {1'b0, 1'b1, miso};
  sfp_port #(.IS_MASTER(1'b1), .DEPTH(8)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .link_in(lin), .link_out(lo), .irq(irq),
    .dma_req(dreq), .dma_ack(dack));
  sfp_slave_model part_u (.hclk(hclk), .lo(lo), .pol(pol), .ph(ph), .nbits(nbits), .miso_word(mw[15:0]),
    .miso(miso), .got(got), .n_words(n_words));
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
    @(posedge hclk);
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic send(input int n, input int keep);
    for (int i = 0; i < n; i++) begin
      w = 16'($random(seed));
      bus(1'b1, 8'h08, {16'h0000, w}, r);
      if (i < keep) begin
        rxq.push_back(16'(mw[15:0] + 16'(k)) & msk);
      end
      k++;
    end
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 400; i++) begin
      bus(1'b0, 8'h0C, 32'h0, r);
      if (r[4] === 1'b0 && r[0] === 1'b1) break;
    end
    chk({30'h0, r[4], r[0]}, 32'h1);
    repeat (4) @(posedge hclk);
  endtask
  task automatic drain(input int n);
    for (int i = 0; i < n; i++) begin
      bus(1'b0, 8'h08, 32'h0, r);
      chk(r, {16'h0000, rxq.pop_front()});
    end
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      conclude();
    end
    if (lo.sel_n === 1'b1 && sel_q === 1'b0) sel_rise++;
    sel_q <= lo.sel_n;
    if (mon && lo.sel_n === 1'b1) chk({31'h0, lo.serial_bit_clock}, {31'h0, pol});
    if (mon) chk({31'h0, lo.tx_output_enable_n}, {31'h0, lo.sel_n});
  end
  initial begin
    seed = 32'hB34AECAB;
    hresetn = 1'b0;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    dack = 2'b00;
    pol = 1'b0;
    ph = 1'b0;
    nbits = 5'h08;
    mon = 1'b0;
    sel_q = 1'b1;
    k = 0;
    mw = $random(seed);
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    chk({27'h0, lo.sel_n, lo.serial_tx_line, lo.serial_bit_clock_oe, lo.tx_output_enable_n, hresp}, 32'h16);
    bus(1'b0, 8'h18, 32'h0, r);
    chk(r, 32'h8);
    bus(1'b0, 8'h40, 32'h0, r);
    chk(r, 32'h0);
    for (int m = 0; m < 4; m++) begin
      mon = 1'b0;
      pol = m[0];
      ph = m[1];
      nbits = 5'(nb_tab[m]);
      msk = 16'((32'h1 << nbits) - 1);
      bus(1'b1, 8'h04, 32'h0, r);
      bus(1'b1, 8'h00, {16'h0000, 8'h01, ph, pol, 2'b00, 4'(nbits - 5'h01)}, r);
      bus(1'b1, 8'h10, 32'h4, r);
      send(4, 4);
      sel_rise = 0;
      bus(1'b0, 8'h18, 32'h0, r);
      chk({31'h0, r[3]}, 32'h1);
      chk({31'h0, lo.sel_n}, 32'h1);
      mon = 1'b1;
      bus(1'b1, 8'h04, 32'h2, r);
      wait_idle();
      chk(32'(sel_rise), ph ? 32'h1 : 32'h4);
      chk({31'h0, lo.serial_tx_line}, 32'h0);
      chk({16'h0000, got}, {16'h0000, w & msk});
      bus(1'b0, 8'h18, 32'h0, r);
      chk({31'h0, r[2]}, 32'h1);
      drain(4);
    end
    send(9, 8);
    wait_idle();
    bus(1'b0, 8'h0C, 32'h0, r);
    chk({31'h0, r[3]}, 32'h1);
    bus(1'b0, 8'h18, 32'h0, r);
    chk({31'h0, r[0]}, 32'h1);
    repeat (300) @(posedge hclk);
    bus(1'b0, 8'h18, 32'h0, r);
    chk(r & 32'h3, 32'h3);
    bus(1'b1, 8'h14, 32'hF, r);
    repeat (2) @(posedge hclk);
    chk({27'h0, irq}, 32'h1F);
    bus(1'b1, 8'h20, 32'h3, r);
    bus(1'b0, 8'h18, 32'h0, r);
    chk(r & 32'h3, 32'h0);
    drain(8);
    bus(1'b1, 8'h14, 32'h8, r);
    repeat (2) @(posedge hclk);
    chk({27'h0, irq}, 32'h9);
    bus(1'b0, 8'h1C, 32'h0, r);
    chk(r, 32'h8);
    bus(1'b1, 8'h14, 32'h0, r);
    repeat (2) @(posedge hclk);
    chk({27'h0, irq}, 32'h0);
    bus(1'b1, 8'h14, 32'h8, r);
    bus(1'b1, 8'h24, 32'h2, r);
    repeat (2) @(posedge hclk);
    chk({31'h0, dreq.tx}, 32'h1);
    chk({31'h0, irq.tx_service_irq}, 32'h0);
    dack <= 2'b01;
    @(posedge hclk);
    dack <= 2'b00;
    @(posedge hclk);
    chk({31'h0, dreq.tx}, 32'h0);
    bus(1'b1, 8'h24, 32'h1, r);
    send(1, 1);
    wait_idle();
    chk({31'h0, dreq.rx}, 32'h1);
    drain(1);
    dack <= 2'b10;
    @(posedge hclk);
    dack <= 2'b00;
    repeat (4) @(posedge hclk);
    chk({31'h0, dreq.rx}, 32'h0);
    conclude();
  end
endmodule
